// ==== common/spi_eeprom_regs.svh ====
// timing and layout constants for the serial memory port
`ifndef SPI_EEPROM_REGS_SVH
`define SPI_EEPROM_REGS_SVH

// =====================================================
// clock rates
`define SYS_CLK_PERIOD_NS   5
`define SCLK_MAX_FREQ_KHZ   4000
// least half period in sys_clk cycles for the fastest serial clock
`define SCLK_MIN_HALF_CYC \
   ((1000000 + 2 * `SCLK_MAX_FREQ_KHZ * `SYS_CLK_PERIOD_NS - 1) / \
    (2 * `SCLK_MAX_FREQ_KHZ * `SYS_CLK_PERIOD_NS))

// =====================================================
// field layout
`define BYTE_WIDTH          8
`define DIV_WIDTH           8
`define BIT_CNT_WIDTH       3
`define CS_RESET_VALUE      1'b1
`define DIV_RESET_VALUE     8'h19

`endif

// ==== common/spi_eeprom_pkg.sv ====
// types for the serial memory port
package spi_eeprom_pkg;

   // =====================================================
   // transfer request and result carriers
   typedef struct packed {
      logic [7:0] data;
   } xfer_req_s;

   typedef struct packed {
      logic [7:0] data;
   } xfer_rsp_s;

   typedef enum logic [1:0] {
      st_idle,
      st_low,
      st_high
   } shift_state_e;

endpackage

// ==== logic/pin_sync.sv ====
// two-stage synchroniser for one pin input
`timescale 1ns/10ps
module pin_sync (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic clk_en,
   input  wire logic pin_in,
   output logic      pin_sync_out
);
   logic meta_q;

   // idle level of the pulled-up data line is one
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_q       <= 1'b1;
         pin_sync_out <= 1'b1;
      end else if (clk_en) begin
         meta_q       <= pin_in;
         pin_sync_out <= meta_q;
      end
   end
endmodule // pin_sync

// ==== logic/serial_eeprom_spi_master.sv ====
// master serial port to an external serial memory
//
// Behaviour
// R01 - serial clock runs at up to 4MHz
// R02 - firmware drives chip select on free pin
// R03 - deselected memory floats its data output
// R04 - serial clock leaves on shared pin zero
// R05 - outgoing bits change on falling clock edge
// R06 - incoming bits captured on rising clock edge
// R07 - board pulls data in and select high; bench pulls only data in, select is reset high by the master
// R08 - select low whole command, msb first
`timescale 1ns/10ps
`include "spi_eeprom_regs.svh"

module serial_eeprom_spi_master (
   input  wire logic                     sys_clk,
   input  wire logic                     rst,
   input  wire logic                     clk_en,
   input  wire logic [`DIV_WIDTH-1:0]    half_period,
   input  wire logic                     xfer_start,
   input  wire spi_eeprom_pkg::xfer_req_s xfer_req,
   input  wire logic                     cs_n_set,
   input  wire logic                     cs_n_value,
   output logic                          xfer_busy,
   output logic                          xfer_done,
   output spi_eeprom_pkg::xfer_rsp_s     xfer_rsp,
   output logic                          gpio_pin_zero,
   output logic                          gpio_pin_one,
   input  wire logic                     gpio_pin_two,
   output logic                          gpio_pin_three
);

   // =====================================================
   // state
   spi_eeprom_pkg::shift_state_e state_q;
   spi_eeprom_pkg::shift_state_e state_d;
   logic [`DIV_WIDTH-1:0]        div_q;
   logic [`DIV_WIDTH-1:0]        div_d;
   logic [`BIT_CNT_WIDTH-1:0]    bit_q;
   logic [`BIT_CNT_WIDTH-1:0]    bit_d;
   logic [`BYTE_WIDTH-1:0]       tx_q;
   logic [`BYTE_WIDTH-1:0]       tx_d;
   logic [`BYTE_WIDTH-1:0]       rx_q;
   logic [`BYTE_WIDTH-1:0]       rx_d;
   logic                         miso_s;
   logic                         sclk_d;
   logic                         so_d;
   logic                         busy_d;
   logic                         done_d;
   logic                         cs_n_d;

   // =====================================================
   // input synchroniser
   // two flops: the memory output is not timed to sys_clk
   pin_sync u_miso_sync (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .clk_en       (clk_en),
      .pin_in       (gpio_pin_two),
      .pin_sync_out (miso_s)
   );

   // =====================================================
   // divider decode
   wire [`DIV_WIDTH-1:0] half_min = `DIV_WIDTH'(`SCLK_MIN_HALF_CYC);
   // a too-small divisor is clamped so the clock never passes 4MHz
   wire [`DIV_WIDTH-1:0] half_lim =
      (half_period < half_min) ? half_min : half_period; // R01
   wire div_end = (div_q == 8'h01);

   // =====================================================
   // state decode
   wire in_idle  = (state_q == spi_eeprom_pkg::st_idle);
   wire in_low   = (state_q == spi_eeprom_pkg::st_low);
   wire in_high  = (state_q == spi_eeprom_pkg::st_high);
   wire last_bit = (bit_q == 3'h0);
   wire go       = xfer_start && in_idle;
   // sclk moves on the edge that ends these cycles
   wire rise_now = in_low && div_end;
   wire fall_now = in_high && div_end;
   wire byte_end = fall_now && last_bit;

   // =====================================================
   // sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         spi_eeprom_pkg::st_idle: begin
            if (go) begin
               state_d = spi_eeprom_pkg::st_low;
            end
         end
         spi_eeprom_pkg::st_low: begin
            if (div_end) begin
               state_d = spi_eeprom_pkg::st_high;
            end
         end
         spi_eeprom_pkg::st_high: begin
            if (div_end) begin
               state_d = last_bit ? spi_eeprom_pkg::st_idle
                                  : spi_eeprom_pkg::st_low;
            end
         end
         default: begin
            state_d = spi_eeprom_pkg::st_idle;
         end
      endcase
   end

   // =====================================================
   // next values
   assign div_d  = go       ? half_lim :
                   in_idle  ? div_q :
                   div_end  ? half_lim : div_q - 8'h01;
   assign bit_d  = go       ? 3'h7 :
                   fall_now ? bit_q - 3'h1 : bit_q;
   // msb leaves first; zeros fill behind it
   assign tx_d   = go       ? xfer_req.data : // R08
                   fall_now ? {tx_q[6:0], 1'h0} : tx_q; // R05
   // sampled as sclk rises, two cycles of sync lag early
   assign rx_d   = rise_now ? {rx_q[6:0], miso_s} : rx_q; // R06
   assign sclk_d = (state_d == spi_eeprom_pkg::st_high); // R04
   // next bit appears on the same edge that lowers sclk
   assign so_d   = tx_d[7]; // R05
   assign busy_d = (state_d != spi_eeprom_pkg::st_idle);
   assign done_d = byte_end;
   assign cs_n_d = cs_n_set ? cs_n_value : gpio_pin_three; // R02

   // =====================================================
   // sequencer register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= spi_eeprom_pkg::st_idle;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   // =====================================================
   // counters
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_q <= `DIV_RESET_VALUE;
      end else if (clk_en) begin
         div_q <= div_d;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bit_q <= 3'h7;
      end else if (clk_en) begin
         bit_q <= bit_d;
      end
   end

   // =====================================================
   // shifters
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tx_q <= 8'h00;
      end else if (clk_en) begin
         tx_q <= tx_d;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rx_q <= 8'h00;
      end else if (clk_en) begin
         rx_q <= rx_d;
      end
   end

   // =====================================================
   // serial pins
   // sclk idles low; the first bit is set up before the first rise
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gpio_pin_zero <= 1'h0;
      end else if (clk_en) begin
         gpio_pin_zero <= sclk_d; // R04
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gpio_pin_one <= 1'h0;
      end else if (clk_en) begin
         gpio_pin_one <= so_d; // R05
      end
   end

   // =====================================================
   // chip select
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gpio_pin_three <= `CS_RESET_VALUE;
      end else if (clk_en) begin
         gpio_pin_three <= cs_n_d; // R02
      end
   end

   // =====================================================
   // status
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         xfer_busy <= 1'h0;
      end else if (clk_en) begin
         xfer_busy <= busy_d;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         xfer_done <= 1'h0;
      end else if (clk_en) begin
         xfer_done <= done_d; // R08
      end
   end

   // =====================================================
   // received byte
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         xfer_rsp <= '0;
      end else if (clk_en && rise_now && last_bit) begin
         xfer_rsp.data <= rx_d; // R06
      end
   end

endmodule // serial_eeprom_spi_master

// ==== tb/spi_chk_assertions.sv ====
// checker for the serial memory port
`timescale 1ns/10ps
module spi_chk (
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       clk_en,
   input wire logic [7:0] half_period,
   input wire logic       xfer_start,
   input wire logic       cs_n_set,
   input wire logic       cs_n_value,
   input wire logic       xfer_busy,
   input wire logic       xfer_done,
   input wire logic       gpio_pin_zero,
   input wire logic       gpio_pin_one,
   input wire logic       gpio_pin_three
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // =====================================================
   // port rules; a frozen edge loads nothing
   a_cs_load: assert property (
      clk_en && cs_n_set |=> gpio_pin_three == $past(cs_n_value))
      else $error("cs");
   a_sclk_idle: assert property (
      !xfer_busy |-> !gpio_pin_zero) else $error("sclk idle");
   a_so_fall: assert property (
      xfer_busy && $past(xfer_busy) && $changed(gpio_pin_one)
      |-> $fell(gpio_pin_zero)) else $error("so edge");
   a_low_half: assert property (
      $rose(gpio_pin_zero) |-> !$past(gpio_pin_zero, 24)) else $error("low");
   a_high_half: assert property (
      $fell(gpio_pin_zero) |-> $past(gpio_pin_zero, 24)) else $error("high");
   a_start_busy: assert property (
      clk_en && xfer_start && !xfer_busy |=> xfer_busy)
      else $error("start");
   a_done_end: assert property (
      $fell(xfer_busy) |-> xfer_done) else $error("done");
   a_byte_len: assert property (
      $rose(xfer_busy) && (half_period <= 8'h3C)
      |-> ##[400:1000] xfer_done) else $error("len");
   cover property (xfer_done);
   cover property (xfer_start && xfer_busy);
   cover property ($fell(gpio_pin_three));
   cover property (!clk_en && xfer_busy);
endmodule // spi_chk
bind serial_eeprom_spi_master spi_chk spi_chk_inst (.sys_clk, .rst,
   .clk_en, .half_period, .xfer_start, .cs_n_set, .cs_n_value,
   .xfer_busy, .xfer_done, .gpio_pin_zero, .gpio_pin_one,
   .gpio_pin_three);

// ==== tb/eeprom_model.sv ====
// behavioural serial memory at the far side
`timescale 1ns/10ps
module eeprom_model #(parameter logic [7:0] REPLY = 8'h5A) (
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   output wire      sdo
);
   logic [7:0] sr_q = REPLY;
   logic       out_q = 1'b0;
   // floats when deselected, board pull-up decides the level
   assign sdo = cs_n ? 1'bz : out_q;
   always @(posedge sclk) if (!cs_n) sr_q <= {sr_q[6:0], sdi};
   always @(negedge cs_n or negedge sclk) out_q <= sr_q[7];
endmodule // eeprom_model

// ==== tb/tb_top.sv ====
// self-checking bench for the serial memory port
`timescale 1ns/10ps
module tb_top;
   logic sys_clk = 1'h0, rst = 1'h1, clk_en = 1'h1, xfer_start = 1'h0;
   logic cs_n_set = 1'h0, cs_n_value = 1'h1, xfer_busy, xfer_done;
   logic gpio_pin_zero, gpio_pin_one, gpio_pin_three;
   logic [7:0] half_period = 8'h0A;
   spi_eeprom_pkg::xfer_req_s xfer_req = '0;
   spi_eeprom_pkg::xfer_rsp_s xfer_rsp;
   wire  gpio_pin_two;
   int   miscompares = 0, comparisons = 0;
   pullup (gpio_pin_two);
   always #2.5 sys_clk = ~sys_clk;
   serial_eeprom_spi_master serial_eeprom_spi_master_inst (.sys_clk, .rst,
      .clk_en, .half_period, .xfer_start, .xfer_req, .cs_n_set,
      .cs_n_value, .xfer_busy, .xfer_done, .xfer_rsp, .gpio_pin_zero,
      .gpio_pin_one, .gpio_pin_two, .gpio_pin_three);
   eeprom_model eeprom_model_inst (.cs_n(gpio_pin_three),
      .sclk(gpio_pin_zero), .sdi(gpio_pin_one), .sdo(gpio_pin_two));
   // =====================================================
   // tasks
   task chk(input logic [15:0] s, input logic [15:0] e, input string n);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s exp %h saw %h", n, e, s);
      end
   endtask
   task set_cs(input logic v);
      @(negedge sys_clk) cs_n_value = v;
      cs_n_set = 1'b1;
      @(negedge sys_clk) cs_n_set = 1'h0;
      chk({15'h0000, gpio_pin_three}, {15'h0000, v}, "cs");
   endtask
   // second start lands while busy and must be ignored;
   // h is the half period after clamping, frz the frozen cycles
   task xfer(input logic [7:0] d, input logic [7:0] e,
             input int h, input int frz);
      int n;
      @(negedge sys_clk) xfer_req.data = d;
      xfer_start = 1'h1;
      @(negedge sys_clk) xfer_req.data = ~d;
      chk({15'h0000, xfer_busy}, 16'h0001, "busy");
      @(negedge sys_clk) xfer_start = 1'h0;
      n = 0;
      while (xfer_done !== 1'h1 && n < 2000) begin
         @(negedge sys_clk);
         n++;
         clk_en = !(n >= 100 && n < 100 + frz);
      end
      chk({15'h0000, xfer_done}, 16'h0001, "done");
      chk(16'(n), 16'(16 * h - 1 + frz), "cycles");
      chk({8'h00, xfer_rsp.data}, {8'h00, e}, "rsp");
   endtask
   task out_reset_chk;
      chk({15'h0000, gpio_pin_three}, 16'h0001, "cs rst");
      chk({15'h0000, gpio_pin_zero}, 16'h0000, "sclk rst");
      chk({15'h0000, xfer_busy}, 16'h0000, "busy rst");
      chk({15'h0000, xfer_done}, 16'h0000, "done rst");
      chk({8'h00, xfer_rsp.data}, 16'h0000, "rsp rst");
   endtask
   // divisor below the limit runs at the clamped 4MHz rate
   task scn_clamped_byte;
      set_cs(1'h0);
      xfer(8'hC3, 8'h5A, 25, 0);
   endtask
   task scn_echo_byte;
      @(negedge sys_clk) half_period = 8'h1E;
      xfer(8'h3C, 8'hC3, 30, 0);
   endtask
   task scn_frozen_byte;
      xfer(8'hA5, 8'h3C, 30, 20);
   endtask
   task scn_deselected;
      set_cs(1'h1);
      xfer(8'h00, 8'hFF, 30, 0);
   endtask
   // reset in mid byte, then a clean byte from idle
   task scn_mid_reset;
      set_cs(1'h0);
      @(negedge sys_clk) xfer_req.data = 8'h81;
      xfer_start = 1'h1;
      @(negedge sys_clk) xfer_start = 1'h0;
      repeat (60) @(negedge sys_clk);
      rst = 1'h1;
      repeat (10) @(negedge sys_clk);
      rst = 1'h0;
      out_reset_chk;
      repeat (2) @(negedge sys_clk);
      out_reset_chk;
      xfer(8'h00, 8'hFF, 30, 0);
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // =====================================================
   // main sequence and watchdog
   initial begin
      repeat (10) @(negedge sys_clk);
      rst = 1'h0;
      out_reset_chk;
      scn_clamped_byte;
      scn_echo_byte;
      scn_frozen_byte;
      scn_deselected;
      scn_mid_reset;
      tally_and_finish;
   end
   // about 2500 cycles are needed; this allows over three times that
   initial begin
      #40000;
      miscompares++;
      tally_and_finish;
   end
endmodule // tb_top
